// [logic/ddsp_pkg.sv]
`default_nettype none
// ==========================================================
// Shared constants of the direct data serial port
package ddsp_pkg;
    // Register location and field layout
    localparam logic [7:0] DDSP_CFG_OFFSET = 8'h0C;
    localparam logic [7:0] DDSP_CFG_RESET  = 8'h00;
    localparam int         DDSP_START_BIT  = 0;
    localparam int         DDSP_FINISH_BIT = 2;
    localparam int         DDSP_TXM_LSB    = 4;
    localparam int         DDSP_RXM_LSB    = 6;
    // Mode select codes
    localparam logic [1:0] DDSP_MODE_OFF   = 2'h0;
    localparam logic [1:0] DDSP_TX_CONT    = 2'h1;
    localparam logic [1:0] DDSP_TX_DATA    = 2'h2;
    localparam logic [1:0] DDSP_RX_CONT    = 2'h1;
    localparam logic [1:0] DDSP_RX_BUF1    = 2'h2;
    localparam logic [1:0] DDSP_RX_BUF2    = 2'h3;
    // Radio state commands
    localparam logic [3:0] DDSP_RADIO_TX   = 4'h9;
    localparam logic [3:0] DDSP_RADIO_RX   = 4'h6;
    localparam logic [3:0] DDSP_RADIO_OFF  = 4'h8;
    // Line coding and bit clock cycles per byte
    typedef enum logic [1:0] {DDSP_NRZ, DDSP_MANCH, DDSP_3OF6} ddsp_coding_t;
    localparam logic [4:0] DDSP_CYC_NRZ    = 5'h08;
    localparam logic [4:0] DDSP_CYC_MANCH  = 5'h10;
    localparam logic [4:0] DDSP_CYC_3OF6   = 5'h0C;
    localparam logic [4:0] DDSP_BYTE_BITS  = 5'h08;
    // Receive buffer
    localparam int         DDSP_BUF_DEPTH  = 64;
    localparam int         DDSP_LEN_W      = 11;
    // Bit timing
    localparam int         DDSP_CLK_NS     = 50;
    localparam int         DDSP_BIT_NS     = 400;
    localparam int         DDSP_HALF_CYC   = DDSP_BIT_NS / (2 * DDSP_CLK_NS);
endpackage : ddsp_pkg
`default_nettype wire

// [logic/ddsp_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Link between device end and host end, wires resolved here
interface ddsp_link_if;
    logic bclk;
    logic bclk_oe_n;
    logic dev_dat;
    logic dev_dat_oe_n;
    logic host_dat;
    logic host_dat_oe_n;
    logic sel;
    logic bclk_line;
    logic data_line;

    // Undriven lines rest low (clock) and high (data pull-up)
    assign bclk_line = !bclk_oe_n ? bclk : 1'b0;
    assign data_line = !dev_dat_oe_n ? dev_dat : (!host_dat_oe_n ? host_dat : 1'b1);

    modport device (output bclk, bclk_oe_n, dev_dat, dev_dat_oe_n, input data_line, sel);
    modport host   (output host_dat, host_dat_oe_n, sel, input bclk_line, data_line);
endinterface : ddsp_link_if
`default_nettype wire

// [logic/ddsp_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Half bit period enable pulse
module ddsp_tick_gen #(
    parameter int unsigned DIV = 4
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic en,
    output logic      tick
);
    localparam int W = $clog2(DIV + 1);
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    logic [W-1:0] cnt_q;

    // Count while enabled, restart when stopped
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            tick  <= en && (cnt_q == LAST);
            cnt_q <= (!en || cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end
endmodule : ddsp_tick_gen
`default_nettype wire

// [logic/ddsp_device.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// - TX continuous: clock runs, sample at falls
// - TX data mode: clock only during payload
// - Host supplies line-coded bits at falls
// - RX continuous: clock runs, bits out, unbuffered
// - Buffered 1: store bytes until sync drops
// - Start shifts oldest byte; overflow overwrites
// - Buffered 1: completion pulse, then ready
// - Host waits one byte before start
// - Early start: unbuffered bits after sync
// - Early finish write ends reception, ready
// - Buffered 2: payload by length, stored
// - Buffered 2: completion after length bytes
// - Host waits sync, length, one byte
// - Software enables both pin-sharing bits
// - Shared TX: select high enables clock, data
// - Shared RX: select high enables clock, data
// - Select low stops clock and data
// - Radio off stops outputs, ignores input
// - Host avoids management access mid-transfer
// - Mode 2 decoded, gated clock; others free (mode 1 held low until first byte)
// - Byte slots 8, 16, 12 cycles
// - One bit period per cycle; start points
module ddsp_device
    import ddsp_pkg::*;
#(
    parameter int unsigned HALF_CYC = DDSP_HALF_CYC
) (
    input  wire logic                  CLK,
    input  wire logic                  RST_N,
    input  wire logic                  CFG_WR,
    input  wire logic [7:0]            CFG_ADDR,
    input  wire logic [7:0]            CFG_WDATA,
    output logic      [7:0]            CFG_RDATA,
    input  wire logic [3:0]            RADIO_CMD,
    input  wire logic [1:0]            CODING,
    input  wire logic                  SHARE_PINS,
    input  wire logic                  TX_PAYLOAD,
    output logic                       TX_BIT,
    output logic                       TX_BIT_VALID,
    input  wire logic                  RX_BIT,
    input  wire logic                  SYNC_FOUND,
    input  wire logic                  RX_SYNC,
    input  wire logic [7:0]            RX_BYTE,
    input  wire logic                  RX_BYTE_VALID,
    input  wire logic                  LEN_VALID,
    input  wire logic [DDSP_LEN_W-1:0] RX_LEN,
    input  wire logic                  HDR_FAIL,
    output logic [DDSP_LEN_W-1:0]      RX_PKT_LEN,
    output logic                       RX_DONE,
    ddsp_link_if.device                link
);
    localparam int AW = $clog2(DDSP_BUF_DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DDSP_BUF_DEPTH);

    typedef enum logic [1:0] {DDSP_IDLE, DDSP_ACTIVE} ddsp_out_t;

    // ==========================================================
    // Declarations
    logic [1:0]            txm_q, rxm_q;
    logic                  sel_s1, sel_s2, din_s1, din_s2;
    ddsp_out_t             out_st_q;
    logic                  direct_q, live_q, buffering_q, len_ok_q;
    logic [7:0]            mem_q [DDSP_BUF_DEPTH];
    logic [AW-1:0]         wr_q, rd_q;
    logic [AW:0]           cnt_q;
    logic [7:0]            sh_q;
    logic [4:0]            slot_q;
    logic [DDSP_LEN_W-1:0] stored_q, sent_q;
    logic                  phase_q, tick, fall;
    logic                  cfg_hit, start_w, fin_w, tx_on, rx_on, mode2, share_ok;
    logic                  tx_run, rx_cont, out_act, run, we, pop, full, done, flush;
    logic                  gate;
    logic [4:0]            slot_lim;

    // ==========================================================
    // Decode and control terms
    assign cfg_hit  = CFG_WR && (CFG_ADDR == DDSP_CFG_OFFSET);
    assign start_w  = cfg_hit && CFG_WDATA[DDSP_START_BIT];
    assign fin_w    = cfg_hit && CFG_WDATA[DDSP_FINISH_BIT];
    assign tx_on    = RADIO_CMD == DDSP_RADIO_TX;
    assign rx_on    = RADIO_CMD == DDSP_RADIO_RX;
    assign mode2    = rxm_q == DDSP_RX_BUF2;
    assign share_ok = !SHARE_PINS || sel_s2;
    assign tx_run   = tx_on && ((txm_q == DDSP_TX_CONT)
                    || (txm_q == DDSP_TX_DATA && TX_PAYLOAD));
    assign rx_cont  = rx_on && (rxm_q == DDSP_RX_CONT);
    assign out_act  = out_st_q == DDSP_ACTIVE;
    assign run      = (tx_run || rx_cont || out_act) && share_ok;
    assign fall     = tick && phase_q;
    assign full     = cnt_q == FULL;
    assign pop      = fall && out_act && !direct_q && cnt_q != '0
                   && (slot_q == 5'h00 || slot_q == slot_lim);
    assign flush    = fin_w || !rx_on || done;
    // Decoded output spends a coding-dependent slot per byte
    always_comb
    begin
        case (CODING)
            DDSP_MANCH: slot_lim = DDSP_CYC_MANCH;
            DDSP_3OF6:  slot_lim = DDSP_CYC_3OF6;
            default:    slot_lim = DDSP_CYC_NRZ;
        endcase
        if (!mode2)
            slot_lim = DDSP_BYTE_BITS;
    end
    assign we = RX_BYTE_VALID && buffering_q
             && (!mode2 || (len_ok_q && stored_q < RX_PKT_LEN));
    assign done = out_act && (direct_q ? (live_q && !RX_SYNC)
                : mode2 ? (len_ok_q && sent_q == RX_PKT_LEN && slot_q == 5'h00)
                : (!buffering_q && cnt_q == '0 && slot_q == 5'h00 && !RX_SYNC));
    // Buffered clock waits for the first byte; in mode 2 it runs only while bits move
    assign gate = !(out_act && !direct_q
                && ((slot_q == 5'h00 && (mode2 || sent_q == '0))
                || (mode2 && slot_q > DDSP_BYTE_BITS)));

    // ==========================================================
    // Bit period divider
    ddsp_tick_gen #(.DIV(HALF_CYC)) u_tick (
        .clk   (CLK),
        .rst_n (RST_N),
        .en    (run),
        .tick  (tick)
    );

    // Pin synchronisers
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            din_s1 <= 1'b1;
            din_s2 <= 1'b1;
        end
        else
        begin
            sel_s1 <= link.sel;
            sel_s2 <= sel_s1;
            din_s1 <= link.data_line;
            din_s2 <= din_s1;
        end
    end

    // Configuration register and readback
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            txm_q     <= DDSP_CFG_RESET[DDSP_TXM_LSB +: 2];
            rxm_q     <= DDSP_CFG_RESET[DDSP_RXM_LSB +: 2];
            CFG_RDATA <= DDSP_CFG_RESET;
        end
        else
        begin
            if (cfg_hit)
            begin
                txm_q <= CFG_WDATA[DDSP_TXM_LSB +: 2];
                rxm_q <= CFG_WDATA[DDSP_RXM_LSB +: 2];
            end
            CFG_RDATA <= {rxm_q, txm_q, 2'b00, buffering_q, out_act};
        end
    end

    // Output engine state
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            out_st_q <= DDSP_IDLE;
            direct_q <= 1'b0;
            live_q   <= 1'b0;
            RX_DONE  <= 1'b0;
        end
        else
        begin
            RX_DONE <= done && !fin_w && rx_on;
            case (out_st_q)
                DDSP_IDLE:
                begin
                    if (start_w && !fin_w && rx_on && rxm_q[1])
                    begin
                        out_st_q <= DDSP_ACTIVE;
                        direct_q <= !buffering_q && cnt_q == '0;
                    end
                end
                DDSP_ACTIVE:
                begin
                    if (direct_q && SYNC_FOUND)
                        live_q <= 1'b1;
                    if (flush)
                    begin
                        out_st_q <= DDSP_IDLE;
                        direct_q <= 1'b0;
                        live_q   <= 1'b0;
                    end
                end
                default: out_st_q <= DDSP_IDLE;
            endcase
        end
    end

    // Buffering control and received length
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            buffering_q <= 1'b0;
            len_ok_q    <= 1'b0;
            stored_q    <= '0;
            RX_PKT_LEN  <= '0;
        end
        else if (flush)
        begin
            buffering_q <= 1'b0;
            len_ok_q    <= 1'b0;
            stored_q    <= '0;
        end
        else
        begin
            if (SYNC_FOUND && rxm_q[1] && !direct_q)
                buffering_q <= 1'b1;
            else if (!mode2 && !RX_SYNC)
                buffering_q <= 1'b0;
            else if (mode2 && (HDR_FAIL || (len_ok_q && stored_q == RX_PKT_LEN)))
                buffering_q <= 1'b0;
            if (mode2 && buffering_q && LEN_VALID)
            begin
                len_ok_q   <= 1'b1;
                RX_PKT_LEN <= RX_LEN;
            end
            if (we)
                stored_q <= stored_q + 1'b1;
        end
    end

    // Receive ring, oldest byte dropped on overflow
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else if (flush)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (we)
                wr_q <= wr_q + 1'b1;
            if (pop || (we && full))
                rd_q <= rd_q + 1'b1;
            if (we && !pop && !full)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !we)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // Buffer storage
    always_ff @(posedge CLK)
    begin
        if (we)
            mem_q[wr_q] <= RX_BYTE;
    end

    // Bit clock phase and byte slot counter
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            phase_q <= 1'b0;
            slot_q  <= 5'h00;
            sent_q  <= '0;
        end
        else
        begin
            if (!run)
                phase_q <= 1'b0;
            else if (tick)
                phase_q <= !phase_q;
            if (flush)
            begin
                slot_q <= 5'h00;
                sent_q <= '0;
            end
            else if (pop)
            begin
                slot_q <= 5'h01;
                sent_q <= sent_q + 1'b1;
            end
            else if (fall && out_act && slot_q != 5'h00)
                slot_q <= (slot_q == slot_lim) ? 5'h00 : slot_q + 1'b1;
        end
    end

    // Shift register and link outputs
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sh_q              <= 8'h00;
            TX_BIT            <= 1'b0;
            TX_BIT_VALID      <= 1'b0;
            link.bclk         <= 1'b0;
            link.bclk_oe_n    <= 1'b1;
            link.dev_dat      <= 1'b0;
            link.dev_dat_oe_n <= 1'b1;
        end
        else
        begin
            TX_BIT_VALID      <= fall && tx_run;
            link.bclk         <= (phase_q ^ tick) && gate && run;
            link.bclk_oe_n    <= !run;
            link.dev_dat_oe_n <= !((rx_cont || out_act) && share_ok);
            if (fall && tx_run)
                TX_BIT <= din_s2;
            if (fall && (rx_cont || (direct_q && live_q)))
                link.dev_dat <= RX_BIT;
            else if (pop)
            begin
                link.dev_dat <= mem_q[rd_q][7];
                sh_q         <= {mem_q[rd_q][6:0], 1'b0};
            end
            else if (fall && out_act && slot_q != 5'h00 && slot_q < DDSP_BYTE_BITS)
            begin
                link.dev_dat <= sh_q[7];
                sh_q         <= {sh_q[6:0], 1'b0};
            end
        end
    end
endmodule : ddsp_device
`default_nettype wire

// [logic/ddsp_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host end: drives select and transmit bits, captures receive bits
module ddsp_host
    import ddsp_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic       SEL_REQ,
    input  wire logic       TX_DRIVE,
    input  wire logic [7:0] TX_BYTE,
    input  wire logic       TX_BYTE_VALID,
    output logic            TX_BYTE_READY,
    output logic [7:0]      RX_BYTE,
    output logic            RX_BYTE_VALID,
    ddsp_link_if.host       link
);
    logic       c_s1, c_s2, c_s3, d_s1, d_s2;
    logic       fall, rise;
    logic [7:0] tx_sh_q, rx_sh_q;
    logic [3:0] tx_left_q, rx_cnt_q;

    assign fall = c_s3 && !c_s2;
    assign rise = !c_s3 && c_s2;

    // Pin synchronisers, third stage for edge detection
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            c_s1 <= 1'b0;
            c_s2 <= 1'b0;
            c_s3 <= 1'b0;
            d_s1 <= 1'b1;
            d_s2 <= 1'b1;
        end
        else
        begin
            c_s1 <= link.bclk_line;
            c_s2 <= c_s1;
            c_s3 <= c_s2;
            d_s1 <= link.data_line;
            d_s2 <= d_s1;
        end
    end

    // Transmit: next bit placed after each device fall
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tx_sh_q            <= 8'h00;
            tx_left_q          <= 4'h0;
            TX_BYTE_READY      <= 1'b1;
            link.host_dat      <= 1'b1;
            link.host_dat_oe_n <= 1'b1;
            link.sel           <= 1'b0;
        end
        else
        begin
            link.sel           <= SEL_REQ;
            link.host_dat_oe_n <= !TX_DRIVE;
            if (TX_BYTE_VALID && TX_BYTE_READY)
            begin
                tx_sh_q       <= TX_BYTE;
                tx_left_q     <= 4'h8;
                TX_BYTE_READY <= 1'b0;
                link.host_dat <= TX_BYTE[7];
            end
            else if (fall && tx_left_q != 4'h0)
            begin
                if (tx_left_q == 4'h1)
                    TX_BYTE_READY <= 1'b1;
                else
                    link.host_dat <= tx_sh_q[6];
                tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
                tx_left_q <= tx_left_q - 1'b1;
            end
        end
    end

    // Receive: bit taken at the rise after the device fall
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rx_sh_q       <= 8'h00;
            rx_cnt_q      <= 4'h0;
            RX_BYTE       <= 8'h00;
            RX_BYTE_VALID <= 1'b0;
        end
        else
        begin
            RX_BYTE_VALID <= 1'b0;
            if (!SEL_REQ)
                rx_cnt_q <= 4'h0;
            else if (rise && TX_DRIVE == 1'b0)
            begin
                rx_sh_q <= {rx_sh_q[6:0], d_s2};
                if (rx_cnt_q == 4'h7)
                begin
                    RX_BYTE       <= {rx_sh_q[6:0], d_s2};
                    RX_BYTE_VALID <= 1'b1;
                    rx_cnt_q      <= 4'h0;
                end
                else
                    rx_cnt_q <= rx_cnt_q + 1'b1;
            end
        end
    end
endmodule : ddsp_host
`default_nettype wire

// [bench/ddsp_link_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Wire checks on the link, pins shared
module ddsp_link_properties (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic bclk,
    input wire logic bclk_oe_n,
    input wire logic dev_dat,
    input wire logic dev_dat_oe_n,
    input wire logic host_dat,
    input wire logic host_dat_oe_n,
    input wire logic sel
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // Select gating of the device drivers, and one end at a time on the data line
    sel_low_quiet_a: assert property (
        !sel && !$past(sel) && !$past(sel, 2) && !$past(sel, 3) |-> bclk_oe_n && dev_dat_oe_n)
        else $error("link driven with select low");
    drive_needs_sel_a: assert property (
        !bclk_oe_n || !dev_dat_oe_n |-> sel || $past(sel) || $past(sel, 2) || $past(sel, 3))
        else $error("link driven without select");
    no_contention_a: assert property (
        !dev_dat_oe_n |-> host_dat_oe_n)
        else $error("both ends drive the data line");
    // Bit clock shape
    bclk_rest_low_a: assert property (bclk_oe_n |-> !bclk)
        else $error("bit clock high while released");
    bclk_high_span_a: assert property (
        $rose(bclk) |-> (bclk || bclk_oe_n)[*4] ##1 !bclk)
        else $error("bit clock high phase not four cycles");
    bclk_low_span_a: assert property (
        $fell(bclk) && !bclk_oe_n |-> (!bclk)[*4])
        else $error("bit clock low phase too short");
    // Data changes only after falling clock
    dev_dat_falls_a: assert property (
        $changed(dev_dat) && !dev_dat_oe_n && !$past(dev_dat_oe_n) |-> !bclk)
        else $error("device data moved while clock high");
    host_dat_falls_a: assert property (
        $changed(host_dat) && !host_dat_oe_n && !$past(host_dat_oe_n) && !bclk_oe_n |-> !bclk)
        else $error("host data moved while clock high");

    // Main scenarios reached
    cover property ($rose(bclk) && !dev_dat_oe_n);
    cover property ($changed(host_dat) && !bclk_oe_n);
    cover property ($fell(sel) && !bclk_oe_n);
endmodule : ddsp_link_properties
`default_nettype wire

// [bench/direct_data_serial_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Both ends joined over the link, driven from user sides
module direct_data_serial_port_test;
    import ddsp_pkg::*;
    localparam int          WD_CYC   = 20000;
    localparam int          BIT_CYC  = 2 * DDSP_HALF_CYC;
    // Rows: address, write data, expected readback
    localparam logic [23:0] ROWS [6] = '{24'h0C1010, 24'h0C2020, 24'h0C4040,
                                         24'h0CC0C0, 24'h0D10C0, 24'h0C1110};
    localparam logic [4:0]  SLOTS [3] = '{DDSP_CYC_NRZ, DDSP_CYC_MANCH, DDSP_CYC_3OF6};
    logic                   clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, sync_found = 1'b0;
    logic                   rx_sync = 1'b0, rx_byte_valid = 1'b0, len_valid = 1'b0;
    logic                   sel_req = 1'b0, tx_drive = 1'b0, tx_byte_valid = 1'b0;
    logic [7:0]             cfg_addr = 8'h00, cfg_wdata = 8'h00, rx_byte = 8'h00, tx_byte = 8'h00;
    logic [3:0]             radio_cmd = DDSP_RADIO_OFF;
    logic [1:0]             coding = 2'h0;
    logic [DDSP_LEN_W-1:0]  rx_len = '0;
    logic [DDSP_LEN_W-1:0]  rx_pkt_len;
    logic [7:0]             cfg_rdata, host_byte;
    logic                   tx_bit, tx_bit_valid, rx_done, tx_byte_ready, host_byte_valid;
    int                     miscompares = 0;
    int                     cmp_count = 0;

    // Clock and the joined ends
    always #(DDSP_CLK_NS / 2) clk = ~clk;
    ddsp_link_if link ();
    ddsp_device u_ddsp_device (.CLK(clk), .RST_N(rst_n), .CFG_WR(cfg_wr), .CFG_ADDR(cfg_addr),
        .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .RADIO_CMD(radio_cmd), .CODING(coding),
        .SHARE_PINS(1'b1), .TX_PAYLOAD(1'b0), .TX_BIT(tx_bit), .TX_BIT_VALID(tx_bit_valid),
        .RX_BIT(1'b0), .SYNC_FOUND(sync_found), .RX_SYNC(rx_sync), .RX_BYTE(rx_byte),
        .RX_BYTE_VALID(rx_byte_valid), .LEN_VALID(len_valid), .RX_LEN(rx_len), .HDR_FAIL(1'b0),
        .RX_PKT_LEN(rx_pkt_len), .RX_DONE(rx_done), .link(link));
    ddsp_host u_ddsp_host (.CLK(clk), .RST_N(rst_n), .SEL_REQ(sel_req), .TX_DRIVE(tx_drive),
        .TX_BYTE(tx_byte), .TX_BYTE_VALID(tx_byte_valid), .TX_BYTE_READY(tx_byte_ready),
        .RX_BYTE(host_byte), .RX_BYTE_VALID(host_byte_valid), .link(link));
    ddsp_link_properties u_ddsp_link_properties (.CLK(clk), .RST_N(rst_n), .bclk(link.bclk),
        .bclk_oe_n(link.bclk_oe_n), .dev_dat(link.dev_dat), .dev_dat_oe_n(link.dev_dat_oe_n),
        .host_dat(link.host_dat), .host_dat_oe_n(link.host_dat_oe_n), .sel(link.sel));

    // ==========================================================
    // Helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cfg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = addr;
        cfg_wdata = data;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask : cfg
    task automatic push(input logic [7:0] data);
        @(negedge clk);
        rx_byte = data;
        rx_byte_valid = 1'b1;
        @(negedge clk);
        rx_byte_valid = 1'b0;
    endtask : push
    task automatic get(output logic [7:0] data, output int cyc);
        for (cyc = 1; cyc < 3000; cyc++)
        begin
            @(negedge clk);
            if (host_byte_valid === 1'b1)
                break;
        end
        data = host_byte;
    endtask : get
    task automatic await_done(output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 300 && !seen; i++)
        begin
            @(negedge clk);
            seen = (rx_done === 1'b1);
        end
    endtask : await_done
    task automatic results;
        $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // ==========================================================
    // Main sequence
    initial
    begin
        logic [7:0] b;
        logic       d;
        int         c;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        chk(cfg_rdata, DDSP_CFG_RESET);
        foreach (ROWS[i])
        begin
            cfg(ROWS[i][23:16], ROWS[i][15:8]);
            repeat (3) @(negedge clk);
            chk(cfg_rdata, ROWS[i][7:0]);
        end
        $display("test config done");
        // Transmit continuous, mode left at 01 by the last row
        sel_req = 1'b1;
        tx_drive = 1'b1;
        tx_byte = 8'hA5;
        tx_byte_valid = 1'b1;
        @(negedge clk);
        tx_byte_valid = 1'b0;
        radio_cmd = DDSP_RADIO_TX;
        b = 8'h00;
        c = 0;
        for (int i = 0; i < 3000 && c < 8; i++)
        begin
            @(negedge clk);
            if (tx_bit_valid === 1'b1)
            begin
                b = {b[6:0], tx_bit};
                c++;
            end
        end
        chk(b, 8'hA5);
        sel_req = 1'b0;
        repeat (4) @(negedge clk);
        chk({7'h00, link.bclk_oe_n}, 8'h01);
        chk({7'h00, tx_byte_ready}, 8'h01);
        sel_req = 1'b1;
        repeat (20) @(negedge clk);
        chk({7'h00, link.bclk_oe_n}, 8'h00);
        radio_cmd = DDSP_RADIO_OFF;
        tx_drive = 1'b0;
        repeat (4) @(negedge clk);
        chk({7'h00, link.bclk_oe_n}, 8'h01);
        sel_req = 1'b0;
        $display("test transmit done");
        // Buffered mode 1, start between two bytes
        radio_cmd = DDSP_RADIO_RX;
        sel_req = 1'b1;
        cfg(8'h0C, 8'h80);
        @(negedge clk);
        sync_found = 1'b1;
        rx_sync = 1'b1;
        @(negedge clk);
        sync_found = 1'b0;
        push(8'h3C);
        repeat (BIT_CYC * 8) @(negedge clk);
        cfg(8'h0C, 8'h81);
        push(8'hC3);
        rx_sync = 1'b0;
        get(b, c);
        chk(b, 8'h3C);
        get(b, c);
        chk(b, 8'hC3);
        await_done(d);
        chk({7'h00, d}, 8'h01);
        $display("test mode one done");
        // Buffered mode 2 under every coding
        for (int k = 0; k < 3; k++)
        begin
            coding = 2'(k);
            cfg(8'h0C, 8'hC0);
            @(negedge clk);
            sync_found = 1'b1;
            rx_sync = 1'b1;
            @(negedge clk);
            sync_found = 1'b0;
            len_valid = 1'b1;
            rx_len = 11'h002;
            @(negedge clk);
            len_valid = 1'b0;
            push(8'h5A);
            push(8'hA5);
            rx_sync = 1'b0;
            repeat (BIT_CYC * 16) @(negedge clk);
            cfg(8'h0C, 8'hC1);
            get(b, c);
            chk(b, 8'h5A);
            get(b, c);
            chk(b, 8'hA5);
            chk(8'(c), 8'(SLOTS[k] * BIT_CYC));
            await_done(d);
            chk({7'h00, d}, 8'h01);
            chk(rx_pkt_len[7:0], 8'h02);
        end
        $display("test mode two done");
        // Early start goes direct; finish bit then ends it quietly
        cfg(8'h0C, 8'h81);
        repeat (3) @(negedge clk);
        chk(cfg_rdata, 8'h81);
        cfg(8'h0C, 8'h84);
        await_done(d);
        chk({7'h00, d}, 8'h00);
        chk(cfg_rdata, 8'h80);
        // Reset in mid-run drops everything back to rest
        cfg(8'h0C, 8'h81);
        repeat (20) @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk(cfg_rdata, DDSP_CFG_RESET);
        chk({7'h00, link.bclk_oe_n}, 8'h01);
        $display("test finish and reset done");
        results();
    end

    // Watchdog against a hung handshake
    initial
    begin
        repeat (WD_CYC) @(posedge clk);
        miscompares++;
        results();
    end
endmodule : direct_data_serial_port_test
`default_nettype wire
